// ==== mxs_pkg.sv ====
// Package for the multiplexer switch control block
package mxs_pkg;
   // ------------------------------------------------------------
   // Sizes and channel codes
   // ------------------------------------------------------------
   localparam int           MXS_GRP_CH     = 12;
   localparam int           MXS_NUM_CH     = 24;
   localparam logic [6:0]   MXS_CH_LAST    = 7'h17;
   localparam logic [6:0]   MXS_GRP_B_BASE = 7'h0C;
   localparam logic [6:0]   MXS_CODE_ISO   = 7'h5A;
   localparam logic [6:0]   MXS_CODE_EXC   = 7'h5B;
   localparam logic [6:0]   MXS_CODE_MEAS  = 7'h5C;
   localparam logic [6:0]   MXS_CODE_2W    = 7'h5D;
   localparam logic [6:0]   MXS_CODE_4W    = 7'h5E;
   // ------------------------------------------------------------
   // Register offsets and reset values
   // ------------------------------------------------------------
   localparam logic [3:0]   MXS_REG_CMD    = 4'h0;
   localparam logic [3:0]   MXS_REG_CHLO   = 4'h1;
   localparam logic [3:0]   MXS_REG_CHHI   = 4'h2;
   localparam logic [3:0]   MXS_REG_BUS    = 4'h3;
   localparam logic [3:0]   MXS_REG_STAT   = 4'h4;
   localparam logic         MXS_ISO_RST    = 1'b0;
   // ------------------------------------------------------------
   // Timing: break-before-make gap and fastest channel change
   // ------------------------------------------------------------
   localparam int           MXS_CLK_MHZ    = 125;
   localparam int           MXS_BBM_NS     = 16;
   localparam int           MXS_BBM_CYC    = (MXS_BBM_NS * MXS_CLK_MHZ + 999) / 1000;
   localparam int           MXS_RATE_HZ    = 100000;
   localparam int           MXS_CHG_CYC    = (MXS_CLK_MHZ * 1000000) / MXS_RATE_HZ;
   // Command field layout: bit 7 is on(1)/off(0), bits 6:0 the code
   localparam int           MXS_CMD_ON_BIT = 7;
endpackage

// ==== mxs_sync.sv ====
// Two-stage synchroniser for pin levels
`timescale 1ns/10ps
module mxs_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // System clock
   input  wire logic         rst,   // Sync reset
   input  wire logic [W-1:0] d,     // Asynchronous level
   output logic      [W-1:0] q      // Synchronised level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mxs_sync_s;
   mxs_sync_s r, next_r;
   always_comb begin
      next_r    = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign q = r.s2;
endmodule // mxs_sync

// ==== mxs_bbm.sv ====
// Break-before-make channel switch driver
`timescale 1ns/10ps
module mxs_bbm
   import mxs_pkg::*;
#(
   parameter int N = MXS_NUM_CH
) (
   input  wire logic         clk,      // System clock
   input  wire logic         rst,      // Sync reset
   input  wire logic [N-1:0] want,     // Requested switch pattern
   output logic      [N-1:0] drive,    // Switch drive, high closes
   output logic              busy      // Gap in progress
);
   typedef struct packed {
      logic [N-1:0] drv;
      logic [N-1:0] hold;
      logic [7:0]   cnt;
   } mxs_bbm_s;
   mxs_bbm_s r, next_r;
   always_comb begin
      next_r = r;
      if (r.cnt != 8'h00) begin
         next_r.cnt = r.cnt - 8'h01;
         if (r.cnt == 8'h01) begin
            next_r.drv = r.hold;
         end
      end else if (want != r.drv) begin
         // Opens act at once, closes wait out the gap
         next_r.drv  = r.drv & want;
         next_r.hold = want;
         if ((want & ~r.drv) != '0) begin
            next_r.cnt = 8'(MXS_BBM_CYC);
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
   assign drive = r.drv;
   assign busy  = r.cnt != 8'h00;

   // A close only ends a gap, and never lands with an open
   property p_bbm_gap;
      @(posedge clk) disable iff (rst)
      ((drive & ~$past(drive)) != '0) |-> ($past(busy) && ((~drive & $past(drive)) == '0));
   endproperty
   a_bbm_gap: assert property (p_bbm_gap) else $error("switch closed without open gap");
   property p_bbm_done;
      @(posedge clk) disable iff (rst)
      $rose(busy) |-> ##[1:4] !busy;
   endproperty
   a_bbm_done: assert property (p_bbm_done) else $error("close gap too long");
endmodule // mxs_bbm

// ==== mxs_ctrl.sv ====
// Multiplexer switch control: decoder, bus-selection and isolation logic
//
// Operation
// - 24 channel switches in two groups of twelve, each switch individually controlled
// - Channels 0..11 are the first group, 12..23 the second group
// - One control per switch position drives both high and low elements
// - Four bus-selection switches: excitation and measure bus per group
// - Bus-selection switches route the group to backplane or voltmeter link
// - Group with open bus-selection switches is cut off from both buses
// - Never both same-type bus-selection switches closed
// - Request closing both same-type switches leaves both open
// - Two isolation relays under one control cut card from backplane
// - Overvoltage flag forces isolation relays open
// - Voltmeter link operation forces isolation relays open
// - Codes 0..23 drive channel switches, code 90 the isolation relays
// - Codes 91..94 drive bus selection; 93 two-wire, 94 four-wire configuration
// - Code 91 excitation bus, 92 measure bus, to selected channel's group
// - Selected channel 0..11 picks first group, 12..23 second group
// - Scanning opens previous channel before closing next
// - Switch path supports 100,000 channel changes per second
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module mxs_ctrl
   import mxs_pkg::*;
(
   input  wire logic        SYS_CLK,      // 125 MHz clock
   input  wire logic        RST,          // Sync reset, active high
   input  wire logic [3:0]  ADDR,         // Register address
   input  wire logic [7:0]  WDATA,        // Write data
   input  wire logic        WR,           // Write strobe
   input  wire logic        RD,           // Read strobe
   output logic      [7:0]  RDATA,        // Read data, cycle after RD
   input  wire logic        LINK_CMD_V,   // Voltmeter link command valid
   input  wire logic [7:0]  LINK_CMD,     // Voltmeter link command
   input  wire logic        LINK_ACTIVE,  // Voltmeter link in use (pin)
   input  wire logic        OVERVOLT,     // Backplane overvoltage flag (pin)
   output logic      [11:0] GRP_A_SW,     // First group switch drives
   output logic      [11:0] GRP_B_SW,     // Second group switch drives
   output logic      [3:0]  BUS_SW,       // ExcA, MeasA, ExcB, MeasB
   output logic             ROUTE_LINK,   // Buses routed to voltmeter link
   output logic             ISO_CLOSE,    // Isolation relays closed
   output logic             FOUR_WIRE     // Four-wire configuration active
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0] {MXS_IDLE, MXS_SETTLE} mxs_state_e;
   typedef struct packed {
      mxs_state_e  st;
      logic [23:0] ch;
      logic [4:0]  sel;
      logic [3:0]  bus;
      logic        iso_req;
      logic        four_w;
      logic        ov_seen;
      logic        bad_code;
      logic [7:0]  rdata;
   } mxs_ctrl_s;
   mxs_ctrl_s r, next_r;

   logic        ov_s;
   logic        link_s;
   logic [23:0] drive;
   logic        bbm_busy;

   mxs_sync #(.W(2)) u_sync (
      .clk (SYS_CLK),
      .rst (RST),
      .d   ({OVERVOLT, LINK_ACTIVE}),
      .q   ({ov_s, link_s})
   );

   // ------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------
   function automatic logic in_grp_b(input logic [4:0] c);
      in_grp_b = {2'b00, c} >= MXS_GRP_B_BASE;
   endfunction

   // Drop any same-type pair requested together
   function automatic logic [3:0] bus_safe(input logic [3:0] b);
      logic [3:0] o;
      o = b;
      if (b[0] && b[2]) begin
         o[0] = 1'b0;
         o[2] = 1'b0;
      end
      if (b[1] && b[3]) begin
         o[1] = 1'b0;
         o[3] = 1'b0;
      end
      bus_safe = o;
   endfunction

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   logic       cmd_v;
   logic [7:0] cmd;
   logic       on;
   logic [6:0] code;
   logic [3:0] want_bus;

   always_comb begin
      // Link commands take precedence only while the link is in use
      cmd_v = (link_s && LINK_CMD_V) || (WR && ADDR == MXS_REG_CMD);
      cmd   = (link_s && LINK_CMD_V) ? LINK_CMD : WDATA;
      on    = cmd[MXS_CMD_ON_BIT];
      code  = cmd[6:0];
   end

   always_comb begin
      next_r   = r;
      want_bus = r.bus;
      next_r.ov_seen = r.ov_seen | ov_s;
      if (cmd_v) begin
         if (code <= MXS_CH_LAST) begin
            next_r.ch[code[4:0]] = on;
            if (on) begin
               next_r.sel = code[4:0];
            end
            next_r.st = MXS_SETTLE;
         end else if (code == MXS_CODE_ISO) begin
            next_r.iso_req = on;
         end else if (code == MXS_CODE_EXC) begin
            want_bus[{1'b0, in_grp_b(r.sel)} * 2] = on;
         end else if (code == MXS_CODE_MEAS) begin
            want_bus[{1'b0, in_grp_b(r.sel)} * 2 + 1] = on;
         end else if (code == MXS_CODE_2W) begin
            next_r.four_w = 1'b0;
         end else if (code == MXS_CODE_4W) begin
            next_r.four_w = on;
         end else begin
            next_r.bad_code = 1'b1;
         end
      end
      next_r.bus = bus_safe(want_bus);
      if (WR && ADDR == MXS_REG_CHLO) begin
         next_r.ch[7:0] = WDATA;
         next_r.st = MXS_SETTLE;
      end
      if (WR && ADDR == MXS_REG_CHHI) begin
         next_r.ch[23:8] = {WDATA, r.ch[15:8]};
         next_r.st = MXS_SETTLE;
      end
      if (WR && ADDR == MXS_REG_BUS) begin
         next_r.bus = bus_safe(WDATA[3:0]);
      end
      if (WR && ADDR == MXS_REG_STAT) begin
         // Clear sticky flags, a new event wins
         next_r.ov_seen  = ov_s | (r.ov_seen & ~WDATA[0]);
         next_r.bad_code = (cmd_v && code > MXS_CH_LAST && (code < MXS_CODE_ISO || code > MXS_CODE_4W))
                           | (r.bad_code & ~WDATA[1]);
      end
      case (r.st)
         MXS_IDLE: begin
            next_r.st = next_r.st;
         end
         MXS_SETTLE: begin
            if (!bbm_busy && drive == r.ch) begin
               next_r.st = cmd_v ? MXS_SETTLE : MXS_IDLE;
            end
         end
         default: begin
            next_r.st = MXS_IDLE;
         end
      endcase
      next_r.rdata = 8'h00;
      if (RD) begin
         case (ADDR)
            MXS_REG_CMD:  next_r.rdata = {1'b0, 2'b00, r.sel};
            MXS_REG_CHLO: next_r.rdata = drive[7:0];
            MXS_REG_CHHI: next_r.rdata = drive[15:8];
            MXS_REG_BUS:  next_r.rdata = {4'h0, r.bus};
            MXS_REG_STAT: next_r.rdata = {1'b0, r.st == MXS_SETTLE, ISO_CLOSE, r.four_w,
                                          link_s, r.iso_req, r.bad_code, r.ov_seen};
            default:      next_r.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         r         <= '0;
         r.iso_req <= MXS_ISO_RST;
         r.st      <= MXS_IDLE;
      end else begin
         r <= next_r;
      end
   end

   mxs_bbm #(.N(MXS_NUM_CH)) u_bbm (
      .clk   (SYS_CLK),
      .rst   (RST),
      .want  (r.ch),
      .drive (drive),
      .busy  (bbm_busy)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign GRP_A_SW   = drive[11:0];
   assign GRP_B_SW   = drive[23:12];
   assign BUS_SW     = r.bus;
   assign ROUTE_LINK = link_s;
   assign ISO_CLOSE  = r.iso_req & ~ov_s & ~link_s;
   assign FOUR_WIRE  = r.four_w;
   assign RDATA      = r.rdata;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_pair_exc;
      @(posedge SYS_CLK) disable iff (RST) !(BUS_SW[0] && BUS_SW[2]);
   endproperty
   a_pair_exc: assert property (p_pair_exc) else $error("both excitation switches closed");

   property p_pair_meas;
      @(posedge SYS_CLK) disable iff (RST) !(BUS_SW[1] && BUS_SW[3]);
   endproperty
   a_pair_meas: assert property (p_pair_meas) else $error("both measure switches closed");

   property p_both_open;
      @(posedge SYS_CLK) disable iff (RST)
      (WR && ADDR == MXS_REG_BUS && WDATA[0] && WDATA[2]) |=> !BUS_SW[0] && !BUS_SW[2];
   endproperty
   a_both_open: assert property (p_both_open) else $error("pair request closed a switch");

   property p_ov;
      @(posedge SYS_CLK) disable iff (RST) ov_s |-> !ISO_CLOSE;
   endproperty
   a_ov: assert property (p_ov) else $error("relays closed under overvoltage");

   property p_link;
      @(posedge SYS_CLK) disable iff (RST) link_s |-> !ISO_CLOSE;
   endproperty
   a_link: assert property (p_link) else $error("relays closed while link in use");

   property p_iso_cmd;
      @(posedge SYS_CLK) disable iff (RST)
      (WR && !link_s && ADDR == MXS_REG_CMD && WDATA == {1'b1, MXS_CODE_ISO}) ##1 (!ov_s && !link_s) |-> ISO_CLOSE;
   endproperty
   a_iso_cmd: assert property (p_iso_cmd) else $error("code 90 did not close relays");

   sequence s_close_a0;
      WR && !link_s && ADDR == MXS_REG_CMD && WDATA == 8'h80;
   endsequence
   property p_ch_close;
      @(posedge SYS_CLK) disable iff (RST) s_close_a0 ##1 (r.ch == 24'h000001) |-> ##[1:4] GRP_A_SW[0];
   endproperty
   a_ch_close: assert property (p_ch_close) else $error("channel 0 not closed in time");

   property p_exc_grp;
      @(posedge SYS_CLK) disable iff (RST)
      (WR && !link_s && ADDR == MXS_REG_CMD && WDATA == {1'b1, MXS_CODE_EXC} && r.sel >= 5'd12 && !BUS_SW[0])
      |=> BUS_SW[2];
   endproperty
   a_exc_grp: assert property (p_exc_grp) else $error("excitation bus to wrong group");

   property p_reset;
      @(posedge SYS_CLK) $fell(RST) |-> GRP_A_SW == '0 && GRP_B_SW == '0 && BUS_SW == '0 && !ISO_CLOSE;
   endproperty
   a_reset: assert property (p_reset) else $error("switches not open after reset");
endmodule // mxs_ctrl

// ==== mxs_link_model.sv ====
// Voltmeter link partner model driving the dedicated command bus
`timescale 1ns/10ps
module mxs_link_model;
   logic       clk;     // Sampled clock, tied by the bench
   logic       active;  // Link in use
   logic       cmd_v;   // Command valid pulse
   logic [7:0] cmd;     // Command byte
   initial begin
      active = 1'b0;
      cmd_v  = 1'b0;
      cmd    = 8'hA5;
   end
   // ------------------------------------------------------------
   // One command, one cycle; bus shows junk when idle
   // ------------------------------------------------------------
   task automatic send(input logic [7:0] c);
      @(posedge clk);
      cmd_v <= 1'b1;
      cmd   <= c;
      @(posedge clk);
      cmd_v <= 1'b0;
      cmd   <= ~c;
      repeat (8) @(posedge clk);
   endtask
   // Sense channel n paired with source channel n+12
   task automatic pair4w(input logic [6:0] n);
      send({1'b1, n});
      send({1'b1, n + 7'h0C});
   endtask
endmodule // mxs_link_model

// ==== testbench.sv ====
// Self-checking testbench for the switch control block
`timescale 1ns/10ps
module testbench
   import mxs_pkg::*;
;
   logic        SYS_CLK, RST, WR, RD, OVERVOLT;
   logic [3:0]  ADDR;
   logic [7:0]  WDATA, RDATA;
   logic [11:0] GRP_A_SW, GRP_B_SW;
   logic [3:0]  BUS_SW;
   logic        ROUTE_LINK, ISO_CLOSE, FOUR_WIRE;
   logic [23:0] sw_all;
   logic [7:0]  rd_v;
   int          error_cnt, n_compared, cyc;
   assign sw_all = {GRP_B_SW, GRP_A_SW};
   mxs_link_model link_u();
   assign link_u.clk = SYS_CLK;
   mxs_ctrl dut_u (
      .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .LINK_CMD_V(link_u.cmd_v), .LINK_CMD(link_u.cmd), .LINK_ACTIVE(link_u.active),
      .OVERVOLT(OVERVOLT), .GRP_A_SW(GRP_A_SW), .GRP_B_SW(GRP_B_SW), .BUS_SW(BUS_SW),
      .ROUTE_LINK(ROUTE_LINK), .ISO_CLOSE(ISO_CLOSE), .FOUR_WIRE(FOUR_WIRE)
   );
   initial begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   // ------------------------------------------------------------
   // Bus tasks and comparison
   // ------------------------------------------------------------
   task automatic stop_test();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge SYS_CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge SYS_CLK);
      WR    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge SYS_CLK);
      RD   <= 1'b0;
      #1 rd_v = RDATA;
   endtask
   // Command write, then let gap and synchronisers settle
   task automatic cmd(input logic [7:0] c);
      wr(MXS_REG_CMD, c);
      repeat (8) @(posedge SYS_CLK);
      #1;
   endtask
   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 4'h0; WDATA = 8'h00; OVERVOLT = 1'b0;
      error_cnt = 0; n_compared = 0; cyc = 0;
      repeat (2) @(posedge SYS_CLK);
      RST <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      #1;
      check("sw_rst", sw_all, 24'h000000);
      check("bus_rst", {20'h0, BUS_SW}, 24'h0);
      check("iso_rst", {23'h0, ISO_CLOSE}, {23'h0, MXS_ISO_RST});
      // Every channel alone, in its own group
      for (int ch = 0; ch < MXS_NUM_CH; ch++) begin
         cmd({1'b1, 7'(ch)});
         check("ch_on", sw_all, 24'h1 << ch);
         check("grp_a", {12'h0, GRP_A_SW}, (ch < 12) ? (24'h1 << ch) : 24'h0);
         cmd({1'b0, 7'(ch)});
         check("ch_off", sw_all, 24'h0);
      end
      // Independent groups, then break-before-make
      cmd(8'h83);
      cmd(8'h8F);
      check("two_grp", sw_all, 24'h008008);
      cmd(8'h03);
      check("grp_b_kept", sw_all, 24'h008000);
      wr(MXS_REG_CMD, 8'h82);
      repeat (2) @(posedge SYS_CLK);
      #1;
      check("gap", {23'h0, GRP_A_SW[2]}, 24'h0);
      repeat (4) @(posedge SYS_CLK);
      #1;
      check("made", {23'h0, GRP_A_SW[2]}, 24'h1);
      // Bus selection follows the selected channel's group
      cmd(8'h8E);
      cmd(8'hDB);
      check("exc_b", {20'h0, BUS_SW}, 24'h4);
      cmd(8'hDC);
      check("meas_b", {20'h0, BUS_SW}, 24'hC);
      cmd(8'h5B);
      cmd(8'h83);
      cmd(8'hDB);
      check("exc_a", {20'h0, BUS_SW}, 24'h9);
      // Same-type pairs are refused as both open
      wr(MXS_REG_BUS, 8'h05);
      cmd(8'h00);
      check("exc_pair", {20'h0, BUS_SW}, 24'h0);
      wr(MXS_REG_BUS, 8'h0A);
      cmd(8'h00);
      check("meas_pair", {20'h0, BUS_SW}, 24'h0);
      wr(MXS_REG_BUS, 8'h06);
      cmd(8'h00);
      check("mixed", {20'h0, BUS_SW}, 24'h6);
      // Wiring mode and a bad code
      cmd(8'hDE);
      check("four_w", {23'h0, FOUR_WIRE}, 24'h1);
      cmd(8'hDD);
      check("two_w", {23'h0, FOUR_WIRE}, 24'h0);
      cmd(8'h99);
      rd(MXS_REG_STAT);
      check("bad_code", {23'h0, rd_v[1]}, 24'h1);
      rd(4'hF);
      check("unmapped", {16'h0, rd_v}, 24'h0);
      // Isolation relays: command, overvoltage, link
      cmd(8'hDA);
      check("iso_on", {23'h0, ISO_CLOSE}, 24'h1);
      @(posedge SYS_CLK) OVERVOLT <= 1'b1;
      cmd(8'h00);
      check("iso_ov", {23'h0, ISO_CLOSE}, 24'h0);
      @(posedge SYS_CLK) OVERVOLT <= 1'b0;
      cmd(8'h00);
      check("iso_back", {23'h0, ISO_CLOSE}, 24'h1);
      rd(MXS_REG_STAT);
      check("ov_seen", {23'h0, rd_v[0]}, 24'h1);
      wr(MXS_REG_STAT, 8'h03);
      rd(MXS_REG_STAT);
      check("ov_clr", {22'h0, rd_v[1:0]}, 24'h0);
      @(posedge SYS_CLK) link_u.active <= 1'b1;
      cmd(8'h00);
      check("iso_link", {23'h0, ISO_CLOSE}, 24'h0);
      check("route", {23'h0, ROUTE_LINK}, 24'h1);
      cmd(8'h03);
      cmd(8'h02);
      cmd(8'h0F);
      link_u.pair4w(7'h02);
      #1;
      check("link_pair", sw_all, 24'h004004);
      @(posedge SYS_CLK) link_u.active <= 1'b0;
      cmd(8'h00);
      check("iso_unlink", {23'h0, ISO_CLOSE}, 24'h1);
      cmd(8'h5A);
      check("iso_off", {23'h0, ISO_CLOSE}, 24'h0);
      stop_test();
   end
endmodule // testbench
